//--- common/prra_pkg.sv
// Purpose: Shared constants for the packet RAM random access block.
// Assumes: An 8-bit host register space and byte-wide buffers.
// Notes:   Only the low pointer bits that the buffers decode form the buffer address.
package prra_pkg;
  // Register offsets in the host register space.
  localparam logic [7:0] RX_DATA_OFS  = 8'h02;
  localparam logic [7:0] TX_DATA_OFS  = 8'h04;
  localparam logic [7:0] PTR_HIGH_OFS = 8'h08;
  localparam logic [7:0] PTR_LOW_OFS  = 8'h09;
  // Reset value of every register, and the answer for unmapped reads.
  localparam logic [7:0] REG_RESET    = 8'h00;
  // Widths and field positions.
  localparam int DATA_W       = 8;
  localparam int PTR_W        = 16;
  localparam int PTR_HIGH_LSB = 8;
  localparam int BUF_ADDR_W   = 12;
  // Buffer indices.
  localparam int NUM_BUF      = 2;
  localparam int TX_BUF       = 0;
  localparam int RX_BUF       = 1;
endpackage : prra_pkg

//--- common/prra_ram_if.sv
// Purpose: Carries the random access port between the register logic and the buffers.
// Assumes: One write strobe per buffer, one shared address and write byte.
// Notes:   Read data is combinational from the buffers.
`timescale 1ns/1ns
interface prra_ram_if;
  logic [prra_pkg::NUM_BUF-1:0]                     wr_sel;
  logic [prra_pkg::BUF_ADDR_W-1:0]                  addr;
  logic [prra_pkg::DATA_W-1:0]                      wdata;
  logic [prra_pkg::NUM_BUF-1:0][prra_pkg::DATA_W-1:0] rdata;

  // Register side drives the access, buffer side answers.
  modport ctrl (output wr_sel, output addr, output wdata, input rdata);
  modport mem  (input wr_sel, input addr, input wdata, output rdata);
endinterface : prra_ram_if

//--- rtl/prra_buffer_ram.sv
// Purpose: Transmit and receive packet buffers behind the random access port.
// Assumes: Writes land on the clock edge, reads are asynchronous.
// Notes:   Contents are not cleared by reset.
`timescale 1ns/1ns
module prra_buffer_ram (
  input  wire logic    clk_sys_in,
  prra_ram_if.mem      ram_if
);

  // One byte array per buffer, each with its own write strobe.
  for (genvar g = 0; g < prra_pkg::NUM_BUF; g++) begin : g_buf
    logic [prra_pkg::DATA_W-1:0] mem_q [2**prra_pkg::BUF_ADDR_W];

    // Store the host byte only when this buffer's strobe is high.
    always_ff @(posedge clk_sys_in) begin
      if (ram_if.wr_sel[g]) begin
        mem_q[ram_if.addr] <= ram_if.wdata;
      end
    end

    // The byte at the shared address is always presented.
    assign ram_if.rdata[g] = mem_q[ram_if.addr];
  end

endmodule : prra_buffer_ram

//--- rtl/prra_top.sv
// Purpose: Host register bank giving random byte access to the packet buffers.
// Assumes: Host strobes are synchronous to clk_sys_in and last one cycle.
// Notes:   Streaming packet engines use their own pointers and never see this one.
//          Pointer bits above the buffer width are kept and read back, but alias.
//          Reserved addresses ignore writes and answer reads with the reset value.
//          Buffer contents survive reset; only the pointer and the answer clear.
`timescale 1ns/1ns

// Function
// R1: High pointer byte register at 0x08.
// R2: Low pointer byte register at 0x09.
// R3: Transmit data read returns byte at pointer.
// R4: Transmit data write stores byte at pointer.
// R5: Receive data read returns byte at pointer.
// R6: Receive data write stores byte at pointer.
// R7: Random path independent of streaming paths.
// R8: Host loads pointer, then one transmit access.
// R9: Host loads pointer, then one receive access.
// R10: One shared pointer, one data register each.
// R11: Host avoids reserved register addresses.
// R12: Pointer never advances on data access.
// R13: Reset clears pointer and data read.
module prra_top (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic [7:0]  host_addr_in,
  input  wire logic        host_wr_in,
  input  wire logic        host_rd_in,
  input  wire logic [7:0]  host_wdata_in,
  output logic      [7:0]  host_rdata_out,
  output logic             host_rvalid_out
);

  // Register bank state and decode wires.
  logic [7:0]                        ptr_high_q;
  logic [7:0]                        ptr_low_q;
  logic [7:0]                        rdata_q;
  logic [7:0]                        rdata_d;
  logic                              rvalid_q;
  wire  [prra_pkg::PTR_W-1:0]        ptr_full;
  wire                               hit_rx;
  wire                               hit_tx;
  wire                               hit_high;
  wire                               hit_low;
  wire                               wr_high;
  wire                               wr_low;
  wire                               hit_map;

  // Port between this bank and the two buffers.
  prra_ram_if ram_if ();

  // Address decode of the four mapped registers.
  assign hit_rx   = (host_addr_in == prra_pkg::RX_DATA_OFS);
  assign hit_tx   = (host_addr_in == prra_pkg::TX_DATA_OFS);
  assign hit_high = (host_addr_in == prra_pkg::PTR_HIGH_OFS);
  assign hit_low  = (host_addr_in == prra_pkg::PTR_LOW_OFS);
  assign wr_high  = host_wr_in & hit_high; // R1
  assign wr_low   = host_wr_in & hit_low;  // R2
  assign hit_map  = hit_rx | hit_tx | hit_high | hit_low;

  // The two pointer bytes form one pointer shared by both buffers.
  // Only the low bits address the buffers, so the upper bits alias.
  assign ptr_full = {ptr_high_q, ptr_low_q}; // R10

  // Buffer access: each data register strobes only its own buffer.
  assign ram_if.addr             = ptr_full[prra_pkg::BUF_ADDR_W-1:0]; // R10
  assign ram_if.wdata            = host_wdata_in;
  assign ram_if.wr_sel[prra_pkg::TX_BUF] = host_wr_in & hit_tx; // R4 R7
  assign ram_if.wr_sel[prra_pkg::RX_BUF] = host_wr_in & hit_rx; // R6 R7

  // Read mux; reserved addresses answer with the reset value.
  // A read and a write of one data register in one cycle return the old byte.
  assign rdata_d = hit_tx   ? ram_if.rdata[prra_pkg::TX_BUF] : // R3
                   hit_rx   ? ram_if.rdata[prra_pkg::RX_BUF] : // R5
                   hit_high ? ptr_high_q :
                   hit_low  ? ptr_low_q  :
                   prra_pkg::REG_RESET;

  // Pointer bytes change only on their own writes, never on data access.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr_high_q <= prra_pkg::REG_RESET; // R13
      ptr_low_q  <= prra_pkg::REG_RESET; // R13
    end else begin
      if (wr_high) begin
        ptr_high_q <= host_wdata_in; // R1 R12
      end
      if (wr_low) begin
        ptr_low_q <= host_wdata_in; // R2 R12
      end
    end
  end

  // Read answer is registered one cycle after the read strobe.
  // It stays put between reads, so a slow host may fetch it late.
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q  <= prra_pkg::REG_RESET; // R13
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= host_rd_in;
      if (host_rd_in) begin
        rdata_q <= rdata_d; // R3 R5
      end
    end
  end

  // Outputs come straight from the answer registers.
  assign host_rdata_out  = rdata_q;
  assign host_rvalid_out = rvalid_q;

  // The two buffers sit behind the shared port.
  prra_buffer_ram u_ram (
    .clk_sys_in (clk_sys_in),
    .ram_if     (ram_if)
  );

  // Checks on the register bank and buffer port.
  ptr_high_load_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R1
    wr_high |=> ptr_high_q == $past(host_wdata_in))
    else $error("High pointer byte did not load the written value.");

  ptr_low_load_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R2
    wr_low |=> ptr_low_q == $past(host_wdata_in))
    else $error("Low pointer byte did not load the written value.");

  tx_read_data_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R3
    (host_rd_in && hit_tx) |=> host_rvalid_out &&
      host_rdata_out == $past(ram_if.rdata[prra_pkg::TX_BUF]))
    else $error("Transmit data read did not return the buffer byte.");

  tx_write_store_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R4
    (host_wr_in && hit_tx) |=> ram_if.rdata[prra_pkg::TX_BUF] == $past(host_wdata_in))
    else $error("Transmit data write was not stored at the pointer.");

  rx_read_data_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R5
    (host_rd_in && hit_rx) |=> host_rvalid_out &&
      host_rdata_out == $past(ram_if.rdata[prra_pkg::RX_BUF]))
    else $error("Receive data read did not return the buffer byte.");

  rx_write_store_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R6
    (host_wr_in && hit_rx) |=> ram_if.rdata[prra_pkg::RX_BUF] == $past(host_wdata_in))
    else $error("Receive data write was not stored at the pointer.");

  buf_write_cause_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R7
    (|ram_if.wr_sel) |-> host_wr_in && (hit_tx || hit_rx) && !(&ram_if.wr_sel))
    else $error("Buffer written without a single data register write.");

  shared_ptr_addr_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
    ram_if.addr == {ptr_high_q[prra_pkg::BUF_ADDR_W-prra_pkg::PTR_HIGH_LSB-1:0], ptr_low_q})
    else $error("Buffer address differs from the shared pointer.");

  ptr_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R12
    ((host_rd_in || host_wr_in) && (hit_tx || hit_rx)) |=> $stable(ptr_full))
    else $error("Pointer moved on a data register access.");

  reset_clear_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R13
    !$past(rst_n_in) |-> ptr_full == 16'h0000 && host_rdata_out == 8'h00 && !host_rvalid_out)
    else $error("Registers not clear after reset.");

  // Read answer timing: one valid pulse per read strobe.
  // The answer byte holds between reads.
  rvalid_after_rd_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R3 R5
    host_rd_in |=> host_rvalid_out)
    else $error("Read strobe gave no valid pulse.");

  rvalid_no_rd_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R3 R5
    !host_rd_in |=> !host_rvalid_out)
    else $error("Valid pulse without a read strobe.");

  rdata_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R3 R5
    !host_rd_in |=> $stable(host_rdata_out))
    else $error("Read answer changed without a read.");

  // Pointer bytes read back and keep their value between their own writes.
  // Reads of any register never move the pointer.
  high_read_back_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R1
    (host_rd_in && hit_high) |=> host_rdata_out == $past(ptr_high_q))
    else $error("High pointer byte did not read back.");

  low_read_back_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R2
    (host_rd_in && hit_low) |=> host_rdata_out == $past(ptr_low_q))
    else $error("Low pointer byte did not read back.");

  high_ptr_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R12
    !wr_high |=> $stable(ptr_high_q))
    else $error("High pointer byte moved without its own write.");

  low_ptr_keep_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R12
    !wr_low |=> $stable(ptr_low_q))
    else $error("Low pointer byte moved without its own write.");

  ptr_keep_on_rd_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R12
    host_rd_in |=> $stable(ptr_full))
    else $error("Pointer moved on a register read.");

  // The buffer address follows a pointer byte one cycle after its write.
  // Only the high byte bits inside the buffer width reach the address.
  low_addr_load_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
    wr_low |=> ram_if.addr[prra_pkg::PTR_HIGH_LSB-1:0] == $past(host_wdata_in))
    else $error("Buffer address did not follow the low pointer byte.");

  high_addr_load_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
    wr_high |=> ram_if.addr[prra_pkg::BUF_ADDR_W-1:prra_pkg::PTR_HIGH_LSB] ==
      $past(host_wdata_in[prra_pkg::BUF_ADDR_W-prra_pkg::PTR_HIGH_LSB-1:0]))
    else $error("Buffer address did not follow the high pointer byte.");

  // A data write reaches only its own buffer.
  // The other buffer's byte at the same pointer stands still.
  tx_keeps_rx_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
    (host_wr_in && hit_tx) |=>
      ram_if.rdata[prra_pkg::RX_BUF] === $past(ram_if.rdata[prra_pkg::RX_BUF]))
    else $error("Transmit data write disturbed the receive buffer.");

  rx_keeps_tx_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R10
    (host_wr_in && hit_rx) |=>
      ram_if.rdata[prra_pkg::TX_BUF] === $past(ram_if.rdata[prra_pkg::TX_BUF]))
    else $error("Receive data write disturbed the transmit buffer.");

  // A read of a reserved address answers with the reset value.
  // Nothing else signals the refusal to the host.
  unmapped_read_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in) // R11
    (host_rd_in && !hit_map) |=> host_rdata_out == prra_pkg::REG_RESET)
    else $error("Reserved address read did not answer zero.");

endmodule : prra_top

//--- testbench/prra_host_model.sv
// Purpose: Host processor model driving the 8-bit register bus.
// Assumes: One-cycle strobes launched just after a rising edge.
// Notes:   Idle address and data are inverted so stale values never pass.
`timescale 1ns/1ns
module prra_host_model (
  input  wire logic       clk_sys_in,
  output logic      [7:0] host_addr_out,
  output logic            host_wr_out,
  output logic            host_rd_out,
  output logic      [7:0] host_wdata_out,
  input  wire logic [7:0] host_rdata_in,
  input  wire logic       host_rvalid_in
);
  // Bus starts idle at time zero.
  initial begin
    host_addr_out  = 8'h00;
    host_wr_out    = 1'b0;
    host_rd_out    = 1'b0;
    host_wdata_out = 8'h00;
  end

  // One strobe cycle, then the answer is taken one edge later.
  task automatic access(input logic is_wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
    @(posedge clk_sys_in);
    #1;
    host_addr_out  = a;
    host_wdata_out = d;
    host_wr_out    = is_wr;
    host_rd_out    = !is_wr;
    @(posedge clk_sys_in);
    #1;
    host_wr_out    = 1'b0;
    host_rd_out    = 1'b0;
    host_addr_out  = ~a;
    host_wdata_out = ~d;
    q = host_rdata_in;
    v = host_rvalid_in;
  endtask : access
endmodule : prra_host_model

//--- testbench/prra_top_tb.sv
// Purpose: Self-checking bench comparing the bank with a queue-free byte model.
// Assumes: Buffers decode the low 12 pointer bits.
// Notes:   Unwritten buffer bytes are never compared.
`timescale 1ns/1ns
module prra_top_tb;
  logic       clk_sys_in, rst_n_in, wr, rd, rvalid, v;
  logic [7:0] addr, wdata, rdata, q, a, d;
  int         n_mismatch = 0, check_count = 0, cycles = 0, ptr = 0;
  byte unsigned mem [2][int];
  logic [7:0] tbl [4] = '{8'h08, 8'h09, 8'h04, 8'h02};

  prra_top u_prra_top (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .host_addr_in(addr),
    .host_wr_in(wr), .host_rd_in(rd), .host_wdata_in(wdata), .host_rdata_out(rdata),
    .host_rvalid_out(rvalid));
  prra_host_model u_prra_host_model (.clk_sys_in(clk_sys_in), .host_addr_out(addr),
    .host_wr_out(wr), .host_rd_out(rd), .host_wdata_out(wdata), .host_rdata_in(rdata),
    .host_rvalid_in(rvalid));

  // Free-running clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Hang guard.
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      conclude();
    end
  end

  // Compares one byte.
  task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Writes a register and updates the model.
  task automatic wr_m(logic [7:0] ra, logic [7:0] rd_);
    u_prra_host_model.access(1'b1, ra, rd_, q, v);
    case (ra)
      8'h08: ptr = {rd_, ptr[7:0]};
      8'h09: ptr = {ptr[15:8], rd_};
      8'h04: mem[0][ptr & 'hfff] = rd_;
      8'h02: mem[1][ptr & 'hfff] = rd_;
      default: ;
    endcase
  endtask : wr_m

  // Reads a register and checks answer and valid pulse.
  task automatic rd_chk(logic [7:0] ra, logic [7:0] exp);
    u_prra_host_model.access(1'b0, ra, 8'h00, q, v);
    chk("rvalid", 8'h01, {7'h00, v});
    chk("rdata", exp, q);
  endtask : rd_chk

  // Prints the counts and the verdict.
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Main sequence: reset, random traffic, reserved places, second reset.
  initial begin
    rst_n_in = 1'b0;
    void'($urandom(32'h6edd));
    repeat (6) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    chk("rdata_rst", 8'h00, rdata);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h09, 8'h00);
    for (int i = 0; i < 80; i++) begin
      a = tbl[$urandom % 4];
      d = 8'($urandom);
      if (a == 8'h08) rd_chk(a, 8'(ptr >> 8));
      else if (a == 8'h09) rd_chk(a, 8'(ptr));
      else if (mem[a == 8'h02].exists(ptr & 'hfff) && d[0])
        rd_chk(a, mem[a == 8'h02][ptr & 'hfff]);
      wr_m(a, d);
    end
    wr_m(8'h08, 8'h12);
    wr_m(8'h09, 8'h34);
    wr_m(8'h04, 8'h5a);
    wr_m(8'h02, 8'ha5);
    rd_chk(8'h04, mem[0][ptr & 'hfff]);
    rd_chk(8'h02, mem[1][ptr & 'hfff]);
    wr_m(8'h08, 8'h02);
    rd_chk(8'h04, mem[0][ptr & 'hfff]);
    rd_chk(8'h02, mem[1][ptr & 'hfff]);
    wr_m(8'h03, 8'ha5);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h0a, 8'h00);
    rd_chk(8'h09, 8'(ptr));
    rst_n_in = 1'b0;
    @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    chk("rvalid_rst", 8'h00, {7'h00, rvalid});
    rd_chk(8'h08, 8'h00);
    conclude();
  end
endmodule : prra_top_tb
